// *** common/upp_pkg.sv ***
// package: pin levels, timing counts and command types for the programmer
package upp_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 100;
  // times in microseconds as printed
  localparam int T_SETUP_US = 2;
  localparam int T_PW_MIN_US = 95;
  localparam int T_PW_MAX_US = 105;
  localparam int T_HOLD_US = 2;
  localparam int SETUP_CYC = T_SETUP_US * CLK_MHZ;
  // nominal pulse: midpoint of the window, rounded within it
  localparam int PW_CYC = ((T_PW_MIN_US + T_PW_MAX_US) / 2) * CLK_MHZ;
  localparam int HOLD_CYC = T_HOLD_US * CLK_MHZ;
  localparam int CNT_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam int SIG_BIT = 9;
  localparam int SEL_BIT = 0;

  typedef enum logic [1:0] {
    CMD_PROGRAM,
    CMD_VERIFY,
    CMD_IDREAD,
    CMD_READ
  } upp_cmd_t;

  typedef struct packed {
    upp_cmd_t            cmd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } upp_req_t;

  typedef struct packed {
    logic [DATA_W-1:0]   data;
    logic                mismatch;
  } upp_rsp_t;
endpackage : upp_pkg

// *** rtl/upp_programmer.sv ***
// programmer that drives the memory's pins for program, verify and id read
`timescale 1ns/10ps
// What this block does
// RULE1 - writes only clear bits, so verify expects the stored byte as sent.
// RULE2 - programming mode is entered with high supply on and chip select low.
// RULE3 - the byte to write is driven on the data pins with the address.
// RULE4 - a low chip select pulse programs; a high one inhibits programming.
// RULE5 - verify is output gate low, chip select high, high supply on.
// RULE6 - each programmed byte is followed by a verify read and compare.
// RULE7 - the device checks margin itself, so only one pulse is issued.
// RULE8 - id mode is entered by raising the signature address line.
// RULE9 - the byte-select line picks manufacturer or device code.
// RULE10 - all other address lines are held low during id reads.
// RULE11 - the program pulse lasts between 95 and 105 microseconds.
// RULE12 - a read drives chip select and output gate both low.
// RULE13 - with chip select high and high supply off the data pins are not driven by the device.
// RULE14 - address and data stay stable over the whole program pulse.
module upp_programmer #(
  parameter int PW_CYCLES = upp_pkg::PW_CYC,
  parameter int SETUP_CYCLES = upp_pkg::SETUP_CYC,
  parameter int HOLD_CYCLES = upp_pkg::HOLD_CYC
) (
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  input  wire logic                       reqValid,
  input  upp_pkg::upp_req_t               req,
  output logic                            reqReady,
  output logic                            rspValid,
  output upp_pkg::upp_rsp_t               rsp,
  output logic [upp_pkg::ADDR_W-1:0]      addrPins,
  output logic [upp_pkg::DATA_W-1:0]      dataPinsOut,
  output logic                            dataPinsOen,
  input  wire logic [upp_pkg::DATA_W-1:0] dataPinsIn,
  output logic                            chipSelN,
  output logic                            outGateN,
  output logic                            progSupplyOn,
  output logic                            sigLineHigh
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD,
    ST_SAMPLE,
    ST_DONE
  } upp_state_t;

  upp_state_t                       state_r;
  upp_pkg::upp_cmd_t                cmd_r;
  logic [upp_pkg::DATA_W-1:0]       target_r;
  logic [upp_pkg::CNT_W-1:0]        cnt_r;
  logic [upp_pkg::DATA_W-1:0]       dinMeta_r;
  logic [upp_pkg::DATA_W-1:0]       dinSync_r;
  logic                             cntDone;
  logic                             isProg;

  assign cntDone = (cnt_r == '0);
  assign isProg  = (cmd_r == upp_pkg::CMD_PROGRAM);

  // two-stage sampling of the returned data
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dinMeta_r <= upp_pkg::DATA_RST;
      dinSync_r <= upp_pkg::DATA_RST;
    end else begin
      dinMeta_r <= dataPinsIn;
      dinSync_r <= dinMeta_r;
    end
  end

  // phase sequencer
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (reqValid)
            state_r <= ST_SETUP;
        end
        ST_SETUP: begin
          if (cntDone)
            state_r <= ST_PULSE;
        end
        ST_PULSE: begin
          if (cntDone)
            state_r <= isProg ? ST_HOLD : ST_SAMPLE;
        end
        ST_HOLD: begin
          if (cntDone)
            state_r <= ST_PULSE;
        end
        ST_SAMPLE: state_r <= ST_DONE;
        ST_DONE:   state_r <= ST_IDLE;
        // unused codes fall back to idle
        default:   state_r <= ST_IDLE;
      endcase
    end
  end

  // interval counter, reloaded when a request is taken and at the end of each timed phase
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (state_r == ST_IDLE) begin
      if (reqValid)
        cnt_r <= upp_pkg::CNT_W'(SETUP_CYCLES);
    end else if (!cntDone) begin
      cnt_r <= cnt_r - 1'b1;
    end else if (state_r == ST_SETUP) begin
      // RULE11 pulse width count
      cnt_r <= upp_pkg::CNT_W'(isProg ? PW_CYCLES : SETUP_CYCLES);
    end else if (state_r == ST_PULSE) begin
      cnt_r <= upp_pkg::CNT_W'(HOLD_CYCLES);
    end else if (state_r == ST_HOLD) begin
      cnt_r <= upp_pkg::CNT_W'(SETUP_CYCLES);
    end
  end

  // request capture; a program turns into its verify
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cmd_r    <= upp_pkg::CMD_READ;
      target_r <= upp_pkg::DATA_RST;
    end else if (state_r == ST_IDLE && reqValid) begin
      cmd_r    <= req.cmd;
      target_r <= req.data;
    end else if (state_r == ST_HOLD && cntDone) begin
      // RULE6 verify after program
      cmd_r <= upp_pkg::CMD_VERIFY;
    end
  end

  // request and answer handshake strobes
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reqReady <= 1'b0;
      rspValid <= 1'b0;
    end else begin
      reqReady <= (state_r == ST_DONE);
      rspValid <= (state_r == ST_SAMPLE);
    end
  end

  // answer data, held until the next answer
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rsp <= '0;
    end else if (state_r == ST_SAMPLE) begin
      rsp.data     <= dinSync_r;
      // RULE1 compare after clear-only write
      rsp.mismatch <= (cmd_r == upp_pkg::CMD_VERIFY) &&
                      (dinSync_r != target_r);
    end
  end

  // address and write data, loaded when a request is taken
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      addrPins    <= upp_pkg::ADDR_RST;
      dataPinsOut <= upp_pkg::DATA_RST;
    // RULE14 loaded only while idle
    end else if (state_r == ST_IDLE && reqValid) begin
      dataPinsOut <= req.data;
      if (req.cmd == upp_pkg::CMD_IDREAD) begin
        // RULE9 byte select kept
        // RULE10 other address lines low
        addrPins <= req.addr &
                    upp_pkg::ADDR_W'(1 << upp_pkg::SEL_BIT);
      end else begin
        addrPins <= req.addr;
      end
    end
  end

  // data pin direction
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dataPinsOen <= 1'b1;
    end else if (state_r == ST_IDLE) begin
      // RULE3 drive data pins
      dataPinsOen <= !(reqValid && req.cmd == upp_pkg::CMD_PROGRAM);
    end else if (state_r == ST_PULSE && cmd_r == upp_pkg::CMD_VERIFY) begin
      dataPinsOen <= 1'b1;
    end
  end

  // chip select and output gate strobes
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      chipSelN <= 1'b1;
      outGateN <= 1'b1;
    end else if (state_r == ST_PULSE) begin
      if (isProg) begin
        // RULE4 low pulse programs
        // RULE7 single pulse only
        chipSelN <= cntDone;
        outGateN <= 1'b1;
      end else if (cmd_r == upp_pkg::CMD_VERIFY) begin
        // RULE5 verify levels
        chipSelN <= 1'b1;
        outGateN <= 1'b0;
      end else begin
        // RULE12 read levels
        chipSelN <= 1'b0;
        outGateN <= 1'b0;
      end
    end else if (state_r == ST_IDLE || state_r == ST_SAMPLE ||
                 state_r == ST_DONE) begin
      // RULE13 release to standby
      chipSelN <= 1'b1;
      outGateN <= 1'b1;
    end
  end

  // programming supply and signature line
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      progSupplyOn <= 1'b0;
      sigLineHigh  <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      // RULE2 high supply for program
      progSupplyOn <= reqValid && (req.cmd == upp_pkg::CMD_PROGRAM ||
                                   req.cmd == upp_pkg::CMD_VERIFY);
      // RULE8 signature line raised
      sigLineHigh  <= reqValid && req.cmd == upp_pkg::CMD_IDREAD;
    end
  end
endmodule : upp_programmer

// *** testbench/upp_eprom_model.sv ***
// behavioural memory device on the programmer pins
`timescale 1ns/10ps
module upp_eprom_model #(
  parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary
  parameter logic [7:0] DEV_CODE = 8'hc3  // arbitrary
) (
  input  wire logic [14:0] addrPins,
  input  wire logic [7:0]  dataPinsOut,
  input  wire logic        dataPinsOen,
  input  wire logic        chipSelN,
  input  wire logic        outGateN,
  input  wire logic        progSupplyOn,
  input  wire logic        sigLineHigh,
  output logic [7:0]       busLvl
);
  logic [7:0] mem [0:32767];
  logic [7:0] val;
  logic [7:0] last;
  logic       drive;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    last = 8'h00;
  end
  always @(posedge chipSelN)
    if (progSupplyOn && outGateN && !dataPinsOen)
      mem[addrPins] = mem[addrPins] & dataPinsOut;
  assign drive = !outGateN && (!chipSelN || progSupplyOn);
  assign val = sigLineHigh ? (addrPins[0] ? DEV_CODE : MFR_CODE)
                           : mem[addrPins];
  always @(drive or val) if (drive) last = val;
  assign busLvl = !dataPinsOen ? dataPinsOut : drive ? val : ~last;
endmodule : upp_eprom_model

// *** testbench/upp_programmer_monitor.sv ***
// pin sequencing assertions for the programmer
`timescale 1ns/10ps
module upp_programmer_monitor (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [14:0] addrPins,
  input wire logic [7:0]  dataPinsOut,
  input wire logic        dataPinsOen,
  input wire logic        chipSelN,
  input wire logic        outGateN,
  input wire logic        progSupplyOn,
  input wire logic        sigLineHigh
);
  // legal pulse window in clock cycles
  localparam int PW_MIN = upp_pkg::T_PW_MIN_US * upp_pkg::CLK_MHZ;
  localparam int PW_MAX = upp_pkg::T_PW_MAX_US * upp_pkg::CLK_MHZ;
  logic [15:0] lowCnt_r;
  always_ff @(posedge sys_clk)
    lowCnt_r <= (!nrst || chipSelN) ? 16'h0 : lowCnt_r + 16'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_pulse_width: assert property (
    $rose(chipSelN) && outGateN && progSupplyOn
    |-> lowCnt_r >= PW_MIN && lowCnt_r <= PW_MAX)
    else $error("pulse width");
  a_pulse_stable: assert property (
    !chipSelN && !$past(chipSelN) && progSupplyOn
    |-> $stable(addrPins) && $stable(dataPinsOut)) else $error("unstable");
  a_prog_drives: assert property (
    !chipSelN && outGateN && progSupplyOn |-> !dataPinsOen)
    else $error("data not driven");
  a_verify_mode: assert property (
    chipSelN && !outGateN |-> progSupplyOn) else $error("verify supply");
  a_no_clash: assert property (
    !outGateN |-> dataPinsOen) else $error("bus clash");
  a_id_address: assert property (
    sigLineHigh |-> addrPins[14:1] == 14'h0) else $error("id address");
  a_id_supply: assert property (
    sigLineHigh && !outGateN |-> !chipSelN && !progSupplyOn)
    else $error("id mode");
  a_verify_after: assert property (
    $rose(chipSelN) && outGateN && progSupplyOn
    |-> ##[1:300] (!outGateN && chipSelN)) else $error("no verify");
endmodule : upp_programmer_monitor
bind upp_programmer upp_programmer_monitor mon_u (
  .sys_clk, .nrst, .addrPins, .dataPinsOut, .dataPinsOen, .chipSelN,
  .outGateN, .progSupplyOn, .sigLineHigh);

// *** testbench/upp_programmer_tb.sv ***
// bench: program, verify, read and id against the memory model
`timescale 1ns/10ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %0t %s", $time, m); end end
module upp_programmer_tb;
  localparam logic [7:0] MFR = 8'h5a; // arbitrary
  localparam logic [7:0] DEV = 8'hc3; // arbitrary
  // wait bound in cycles, above one full program and verify
  localparam int LIMIT = 20000;
  logic sys_clk, nrst, reqValid, reqReady, rspValid, dataPinsOen, chipSelN;
  logic outGateN, progSupplyOn, sigLineHigh;
  logic [14:0] addrPins;
  logic [7:0] dataPinsOut, busLvl;
  upp_pkg::upp_req_t req;
  upp_pkg::upp_rsp_t rsp, got;
  int fails, total_checks;
  // full-length timing so the pulse window holds
  upp_programmer dut_u (
    .sys_clk, .nrst, .reqValid, .req, .reqReady, .rspValid, .rsp, .addrPins,
    .dataPinsOut, .dataPinsOen, .dataPinsIn(busLvl), .chipSelN, .outGateN,
    .progSupplyOn, .sigLineHigh);
  upp_eprom_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev_u (.addrPins,
    .dataPinsOut, .dataPinsOen, .chipSelN, .outGateN, .progSupplyOn,
    .sigLineHigh, .busLvl);
  task automatic results;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic doReq(input upp_pkg::upp_cmd_t c, input logic [14:0] a,
                       input logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    req = '{c, a, d};
    reqValid = 1'b1;
    while (n < LIMIT && rspValid !== 1'b1) begin
      @(negedge sys_clk);
      n++;
    end
    got = rsp;
    while (n < LIMIT && reqReady !== 1'b1) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= LIMIT) begin
      fails++;
      results();
    end
    reqValid = 1'b0;
  endtask : doReq
  task automatic tProgram;
    doReq(upp_pkg::CMD_PROGRAM, 15'h7fff, 8'ha5);
    `CHK(got, {8'ha5, 1'b0}, "program")
    doReq(upp_pkg::CMD_READ, 15'h7fff, 8'h00);
    `CHK(got.data, 8'ha5, "read back")
    doReq(upp_pkg::CMD_PROGRAM, 15'h7fff, 8'h5a);
    `CHK(got, {8'h00, 1'b1}, "reprogram")
  endtask : tProgram
  task automatic tVerify;
    doReq(upp_pkg::CMD_VERIFY, 15'h7ffe, 8'h00);
    `CHK(got.data, 8'hff, "neighbour")
    `CHK(got.mismatch, 1'b1, "verify flag")
  endtask : tVerify
  task automatic tIdRead;
    doReq(upp_pkg::CMD_IDREAD, 15'h7ffe, 8'h00);
    `CHK(got.data, MFR, "maker byte")
    doReq(upp_pkg::CMD_IDREAD, 15'h0001, 8'h00);
    `CHK(got.data, DEV, "device byte")
  endtask : tIdRead
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    nrst = 1'b0;
    reqValid = 1'b0;
    req = '0;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    tProgram();
    tVerify();
    tIdRead();
    results();
  end
endmodule : upp_programmer_tb
